/* inc/gpap_pkg.sv */
// Constants, types and register map of the GPIO port block with alternate pin steering
// Summary of operation
// - Enabled peripheral overrides latch; pin stays readable
// - Latch write equals pin-level register write
// - Latch read gives latch; pin read gives pins
// - Analog select disables the digital input buffer
// - Steering leaves direction alone, overrides reach chosen pin
// - Selector bit 1: porta line5 or line0
// - Selector bit 0: portc line1 or portb line3
// - Direction 1 is input, 0 drives latch
// - Analog pins read zero through pin-level register
// - Analog select resets to the analog setting
// - Port writes land in the output latch
package gpap_pkg;

   // ***********************************************
   // Geometry
   // ***********************************************
   localparam int GPAP_NPORT = 3;          // Ports A, B, C
   localparam int GPAP_W = 8;              // Lines per port
   localparam int GPAP_AW = 7;             // Avalon byte address width
   localparam int GPAP_PORT_A = 0;
   localparam int GPAP_PORT_B = 1;
   localparam int GPAP_PORT_C = 2;

   // ***********************************************
   // Register map (byte offsets, one word each)
   // ***********************************************
   localparam int GPAP_PORT_STRIDE = 32;   // Distance between port register groups
   localparam int GPAP_OFF_DIR = 0;        // direction_reg
   localparam int GPAP_OFF_PIN = 4;        // pin_level_reg
   localparam int GPAP_OFF_LAT = 8;        // output_latch_reg
   localparam int GPAP_OFF_ANS = 12;       // analog_select_reg
   localparam int GPAP_OFF_WPU = 16;       // pull_up_enable_reg
   localparam int GPAP_OFF_APF = 96;       // alt_pin_function_select

   // ***********************************************
   // Reset values
   // ***********************************************
   localparam logic [7:0] GPAP_RST_DIR = 8'hff;  // All lines input
   localparam logic [7:0] GPAP_RST_LAT = 8'h00;
   localparam logic [7:0] GPAP_RST_ANS = 8'hff;  // All lines analog
   localparam logic [7:0] GPAP_RST_WPU = 8'h00;
   localparam logic [7:0] GPAP_RST_APF = 8'h00;

   // ***********************************************
   // Selector fields and steered line positions
   // ***********************************************
   localparam int GPAP_APF_SS_BIT = 1;     // slave_select_pin_choice
   localparam int GPAP_APF_CAPTURE_COMPARE_UNIT_TWO_BIT = 0;   // compare2_pin_choice
   localparam logic [7:0] GPAP_APF_MASK = 8'h03;  // Implemented selector bits
   localparam int GPAP_PORTA_LINE5 = 5;    // Slave select, choice 0
   localparam int GPAP_PORTA_LINE0 = 0;    // Slave select, choice 1
   localparam int GPAP_PORTC_LINE1 = 1;    // Unit two, choice 0
   localparam int GPAP_PORTB_LINE3 = 3;    // Unit two, choice 1

   // ***********************************************
   // Types
   // ***********************************************
   typedef logic [GPAP_W-1:0] gpap_byte_t;

   // Software state of one port
   typedef struct packed {
      gpap_byte_t dir;
      gpap_byte_t lat;
      gpap_byte_t ans;
      gpap_byte_t wpu;
   } gpap_portRegs_t;

   // Pad driver bundle of one port
   typedef struct packed {
      gpap_byte_t level;
      gpap_byte_t enable;
   } gpap_padDrv_t;

   // Bus handshake states
   typedef enum logic [1:0] {
      GPAP_BUS_IDLE = 2'b01,
      GPAP_BUS_ACK = 2'b10
   } gpap_busState_t;

endpackage

/* core/gpap_sync.sv */
// Two-stage synchroniser for asynchronous pad levels
`timescale 1ns/1ns
module gpap_sync import gpap_pkg::*; #(
   parameter int WIDTH = 24
) (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic [WIDTH-1:0] asyncIn,
   output logic [WIDTH-1:0] syncOut
);

   // First stage, read only by the second stage
   logic [WIDTH-1:0] meta_r;

   // ***********************************************
   // Double flop
   // ***********************************************
   // Metastability settles in the first stage before logic sees it
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         meta_r <= '0;
         syncOut <= '0;
      end else begin
         meta_r <= asyncIn;
         syncOut <= meta_r;
      end
   end

endmodule

/* core/gpap_port.sv */
// GPIO ports A to C with direction, latch, analog, pull-up and alternate pin steering
`timescale 1ns/1ns
module gpap_port import gpap_pkg::*; (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic [GPAP_AW-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic [GPAP_NPORT-1:0][GPAP_W-1:0] padIn,
   output gpap_padDrv_t [GPAP_NPORT-1:0] padDrv,
   output logic [GPAP_NPORT-1:0][GPAP_W-1:0] inBufEn,
   output logic [GPAP_NPORT-1:0][GPAP_W-1:0] pullUpEn,
   input wire logic [GPAP_NPORT-1:0][GPAP_W-1:0] periphEn,
   input wire logic [GPAP_NPORT-1:0][GPAP_W-1:0] periphOe,
   input wire logic [GPAP_NPORT-1:0][GPAP_W-1:0] periphData,
   input wire logic ccp2En,
   input wire logic ccp2Oe,
   input wire logic ccp2Data,
   output logic ccp2In,
   output logic ssIn
);

   // ***********************************************
   // Declarations
   // ***********************************************
   gpap_portRegs_t regs_r [GPAP_NPORT];      // Per-port software registers
   gpap_byte_t apf_r;                        // alt_pin_function_select
   gpap_busState_t busState_r;               // Handshake state
   gpap_busState_t busState_nxt;
   logic [GPAP_NPORT-1:0][GPAP_W-1:0] padSync;  // Synchronised pad levels
   gpap_byte_t digIn [GPAP_NPORT];           // Levels after input buffer
   gpap_byte_t rdPort [GPAP_NPORT];          // Read data of each port group
   gpap_byte_t ccpMask [GPAP_NPORT];         // Line taken by unit two
   gpap_byte_t rdApf;
   gpap_byte_t rdByte;
   gpap_byte_t wrByte;
   logic busReq;
   logic busCapture;
   logic busAccept;
   logic wrEn;
   logic hitApf;
   logic ccpOnC1;
   logic ccpOnB3;

   // Register hit: compares the bus address to a port group offset
   function automatic logic regHit(input logic [GPAP_AW-1:0] addr, input int port,
                                   input int off);
      logic [GPAP_AW-1:0] target;
      target = GPAP_AW'(port * GPAP_PORT_STRIDE + off);
      return addr == target;
   endfunction

   // ***********************************************
   // Pad input synchroniser
   // ***********************************************
   // Pads are asynchronous; two flops stand before any decode reads them
   // Costs two cycles of latency on every pin-level read
   gpap_sync #(.WIDTH(GPAP_NPORT * GPAP_W)) uSync (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .asyncIn(padIn),
      .syncOut(padSync)
   );

   // ***********************************************
   // Avalon handshake
   // ***********************************************
   // One wait state: request seen with waitrequest high, served on the next edge
   // Fixed latency keeps the slave free of any address-dependent timing
   assign busReq = avs_read | avs_write;
   assign busCapture = busReq & avs_waitrequest;
   // Accept cycle is the one that follows a capture
   assign busAccept = busReq & (busState_r == GPAP_BUS_ACK);
   assign wrEn = avs_write & busAccept & avs_byteenable[0];
   assign wrByte = avs_writedata[7:0];
   assign busState_nxt = busCapture ? GPAP_BUS_ACK : GPAP_BUS_IDLE;
   assign hitApf = regHit(avs_address, 0, GPAP_OFF_APF);

   // State and registered waitrequest
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         busState_r <= GPAP_BUS_IDLE;
         avs_waitrequest <= 1'b1;
      end else begin
         busState_r <= busState_nxt;
         avs_waitrequest <= (busState_nxt != GPAP_BUS_ACK);
      end
   end

   // ***********************************************
   // Alternate pin selector
   // ***********************************************
   // Only implemented bits are stored, the rest read zero
   // Masking on write and on read keeps bits 7 to 2 at zero
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         apf_r <= GPAP_RST_APF;
      end else if (wrEn && hitApf) begin
         apf_r <= wrByte & GPAP_APF_MASK;
      end
   end
   assign rdApf = hitApf ? (apf_r & GPAP_APF_MASK) : 8'h00;

   // Unit two lands on exactly one of its two candidate lines
   assign ccpOnC1 = ccp2En & ~apf_r[GPAP_APF_CAPTURE_COMPARE_UNIT_TWO_BIT];
   assign ccpOnB3 = ccp2En & apf_r[GPAP_APF_CAPTURE_COMPARE_UNIT_TWO_BIT];
   assign ccpMask[GPAP_PORT_A] = 8'h00;
   assign ccpMask[GPAP_PORT_B] = ccpOnB3 ? (8'h01 << GPAP_PORTB_LINE3) : 8'h00;
   assign ccpMask[GPAP_PORT_C] = ccpOnC1 ? (8'h01 << GPAP_PORTC_LINE1) : 8'h00;

   // Steered inputs: the unselected line is never sampled for the function
   // Registered so the steering mux never reaches an output directly
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         ssIn <= 1'b0;
         ccp2In <= 1'b0;
      end else begin
         ssIn <= apf_r[GPAP_APF_SS_BIT] ? digIn[GPAP_PORT_A][GPAP_PORTA_LINE0]
                                        : digIn[GPAP_PORT_A][GPAP_PORTA_LINE5];
         ccp2In <= apf_r[GPAP_APF_CAPTURE_COMPARE_UNIT_TWO_BIT] ? digIn[GPAP_PORT_B][GPAP_PORTB_LINE3]
                                            : digIn[GPAP_PORT_C][GPAP_PORTC_LINE1];
      end
   end

   // ***********************************************
   // Per-port logic
   // ***********************************************
   // One copy per port; the genvar is the port index
   for (genvar p = 0; p < GPAP_NPORT; p++) begin : gPort
      logic hitDir;
      logic hitPin;
      logic hitLat;
      logic hitAns;
      logic hitWpu;
      gpap_byte_t ovEn;   // Lines owned by a peripheral
      gpap_byte_t ovOe;   // Peripheral direction for owned lines
      gpap_byte_t ovData; // Peripheral level for owned lines

      assign hitDir = regHit(avs_address, p, GPAP_OFF_DIR);
      assign hitPin = regHit(avs_address, p, GPAP_OFF_PIN);
      assign hitLat = regHit(avs_address, p, GPAP_OFF_LAT);
      assign hitAns = regHit(avs_address, p, GPAP_OFF_ANS);
      assign hitWpu = regHit(avs_address, p, GPAP_OFF_WPU);

      // Analog lines have their input buffer off and read as zero
      assign digIn[p] = padSync[p] & ~regs_r[p].ans;

      // Read mux: latch gives stored value, pin level gives pad state
      // Unselected groups give zero so that the groups can simply be ORed
      assign rdPort[p] = hitDir ? regs_r[p].dir :
                         hitPin ? digIn[p] :
                         hitLat ? regs_r[p].lat :
                         hitAns ? regs_r[p].ans :
                         hitWpu ? regs_r[p].wpu : 8'h00;

      // Overrides: unit two's steered line on top of the generic peripherals
      // Unit two wins over the generic override on its steered line
      assign ovEn = periphEn[p] | ccpMask[p];
      assign ovOe = (periphOe[p] & ~ccpMask[p]) | ({GPAP_W{ccp2Oe}} & ccpMask[p]);
      assign ovData = (periphData[p] & ~ccpMask[p]) | ({GPAP_W{ccp2Data}} & ccpMask[p]);

      // Software registers; the selector never touches direction
      // Direction writes are the only path into the direction register
      always_ff @(posedge core_clk or posedge sys_rst) begin
         if (sys_rst) begin
            regs_r[p].dir <= GPAP_RST_DIR;
            regs_r[p].lat <= GPAP_RST_LAT;
            regs_r[p].ans <= GPAP_RST_ANS;
            regs_r[p].wpu <= GPAP_RST_WPU;
         end else if (wrEn) begin
            if (hitDir) begin
               regs_r[p].dir <= wrByte;
            end
            // Both the pin-level and the latch address write the latch
            if (hitLat || hitPin) begin
               regs_r[p].lat <= wrByte;
            end
            if (hitAns) begin
               regs_r[p].ans <= wrByte;
            end
            if (hitWpu) begin
               regs_r[p].wpu <= wrByte;
            end
         end
      end

      // Pad drive: peripheral wins, otherwise direction gates the latch
      always_ff @(posedge core_clk or posedge sys_rst) begin
         if (sys_rst) begin
            padDrv[p] <= '{level: 8'h00, enable: 8'h00};
            inBufEn[p] <= 8'h00;
            pullUpEn[p] <= 8'h00;
         end else begin
            padDrv[p].level <= (ovEn & ovData) | (~ovEn & regs_r[p].lat);
            padDrv[p].enable <= (ovEn & ovOe) | (~ovEn & ~regs_r[p].dir);
            inBufEn[p] <= ~regs_r[p].ans;
            pullUpEn[p] <= regs_r[p].wpu;
         end
      end
   end

   // ***********************************************
   // Read data
   // ***********************************************
   // Sampled on the capture edge, stands while waitrequest is low
   // Upper bytes are tied to zero; every register is one byte wide
   assign rdByte = rdPort[GPAP_PORT_A] | rdPort[GPAP_PORT_B] | rdPort[GPAP_PORT_C] | rdApf;

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         avs_readdata <= 32'h0000_0000;
      end else if (busCapture && avs_read) begin
         avs_readdata <= {24'h00_0000, rdByte};
      end
   end

   // ***********************************************
   // Assertions
   // ***********************************************
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (sys_rst);
   // First edge after reset still shows reset outputs, so some antecedents need !sys_rst

   // Read of port A pin level seen on the capture edge
   sequence s_rdPinA;
      avs_read && avs_waitrequest && avs_address == GPAP_AW'(GPAP_OFF_PIN);
   endsequence

   // Accepted write to port B latch
   sequence s_wrLatB;
      avs_write && !avs_waitrequest && avs_byteenable[0] &&
         avs_address == GPAP_AW'(GPAP_PORT_STRIDE + GPAP_OFF_LAT);
   endsequence

   // Accepted write to port C pin level
   sequence s_wrPinC;
      avs_write && !avs_waitrequest && avs_byteenable[0] &&
         avs_address == GPAP_AW'(2 * GPAP_PORT_STRIDE + GPAP_OFF_PIN);
   endsequence

   // Any request captured
   sequence s_capture;
      (avs_read || avs_write) && avs_waitrequest;
   endsequence

   a_wait_one_state: assert property (s_capture |=> !avs_waitrequest ##1 avs_waitrequest)
      else $error("waitrequest not low for exactly one cycle");
   a_pin_read_value: assert property (s_rdPinA |=> avs_readdata[7:0] == $past(digIn[0]))
      else $error("pin-level read differs from pad state");
   a_analog_reads_zero: assert property (
      s_rdPinA |=> (avs_readdata[7:0] & $past(regs_r[0].ans)) == 8'h00)
      else $error("analog line read as one");
   a_latch_write_path: assert property (
      s_wrLatB |=> regs_r[1].lat == $past(avs_writedata[7:0]))
      else $error("latch write not stored");
   a_pin_write_latch: assert property (
      s_wrPinC |=> regs_r[2].lat == $past(avs_writedata[7:0]))
      else $error("pin-level write did not reach latch");
   a_periph_owns_pin: assert property (
      !sys_rst |=> ((padDrv[0].level ^ $past(periphData[0])) & $past(periphEn[0])) == 8'h00)
      else $error("latch drove a peripheral-owned line");
   a_dir_input_off: assert property (
      !sys_rst |=> (padDrv[0].enable & $past(regs_r[0].dir & ~periphEn[0])) == 8'h00)
      else $error("driver on for an input line");
   a_ss_route: assert property (
      !sys_rst |=> ssIn == ($past(apf_r[1]) ? $past(digIn[0][0]) : $past(digIn[0][5])))
      else $error("slave select taken from wrong line");
   a_capture_compare_unit_two_place: assert property (
      !sys_rst && ccp2En && !apf_r[0] |=> padDrv[2].level[1] == $past(ccp2Data))
      else $error("unit two not on port C line 1");
   a_unsel_pin_free: assert property (
      !sys_rst && ccp2En && !apf_r[0] && !periphEn[1][3] |=>
         padDrv[1].level[3] == $past(regs_r[1].lat[3]))
      else $error("unselected line disturbed");
   a_apf_readback: assert property (
      avs_read && avs_waitrequest && hitApf |=> avs_readdata[7:2] == 6'h00)
      else $error("unimplemented selector bits read nonzero");
   a_reset_analog: assert property ($fell(sys_rst) |-> regs_r[0].ans == GPAP_RST_ANS)
      else $error("analog select not set after reset");

   // Side effects and plain copies

   // Accepted write to the selector
   sequence s_wrApf;
      avs_write && !avs_waitrequest && avs_byteenable[0] && hitApf;
   endsequence

   a_inbuf_analog: assert property (
      !sys_rst |=> inBufEn[1] == ~$past(regs_r[1].ans))
      else $error("input buffer on for an analog line");
   a_be_gate_latch: assert property (
      avs_write && !avs_waitrequest && !avs_byteenable[0] &&
         avs_address == GPAP_AW'(GPAP_OFF_LAT) |=> $stable(regs_r[0].lat))
      else $error("latch written with byte lane off");
   a_apf_keeps_dir: assert property (
      s_wrApf |=> $stable(regs_r[0].dir) && $stable(regs_r[1].dir) && $stable(regs_r[2].dir))
      else $error("selector write changed a direction register");
   a_capture_compare_unit_two_input: assert property (
      !sys_rst |=> ccp2In == ($past(apf_r[0]) ? $past(digIn[1][3]) : $past(digIn[2][1])))
      else $error("unit two input taken from wrong line");
   a_pullup_copy: assert property (
      !sys_rst |=> pullUpEn[2] == $past(regs_r[2].wpu))
      else $error("pull-up output differs from its register");

endmodule

/* verif/gpap_pads.sv */
// Pad and far-side line model for the GPIO port bench
`timescale 1ns/1ns
module gpap_pads import gpap_pkg::*; (
   input wire logic core_clk,
   input wire gpap_padDrv_t [GPAP_NPORT-1:0] padDrv,
   input wire logic [GPAP_NPORT-1:0][GPAP_W-1:0] pullUpEn,
   input wire logic [GPAP_NPORT-1:0][GPAP_W-1:0] extLevel,
   input wire logic [GPAP_NPORT-1:0] extEn,
   output logic [GPAP_NPORT-1:0][GPAP_W-1:0] padIn
);
   // ***********************************************
   // Floating line pattern
   // ***********************************************
   logic floatPat_r = 1'b0; // Toggles so a floating line never looks stable

   // Free-running toggle for lines nobody drives
   always @(posedge core_clk) begin
      floatPat_r <= ~floatPat_r;
   end

   // ***********************************************
   // Wire resolution
   // ***********************************************
   // Chip driver first, then the outside world, then the weak pull-up
   always_comb begin
      for (int p = 0; p < GPAP_NPORT; p++) begin
         for (int b = 0; b < GPAP_W; b++) begin
            if (padDrv[p].enable[b]) begin
               padIn[p][b] = padDrv[p].level[b];
            end else if (extEn[p]) begin
               padIn[p][b] = extLevel[p][b];
            end else if (pullUpEn[p][b]) begin
               padIn[p][b] = 1'b1;
            end else begin
               padIn[p][b] = floatPat_r; // No keeper on the line
            end
         end
      end
   end
endmodule

/* verif/gpap_port_bench.sv */
// Self-checking bench for the GPIO port block
`timescale 1ns/1ns
module gpap_port_bench import gpap_pkg::*;;
   // ***********************************************
   // Signals
   // ***********************************************
   logic core_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic [GPAP_AW-1:0] avs_address = '0;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = '0;
   logic [3:0] avs_byteenable = 4'h1;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic [GPAP_NPORT-1:0][GPAP_W-1:0] padIn, inBufEn, pullUpEn, extLevel = '0;
   logic [GPAP_NPORT-1:0][GPAP_W-1:0] periphEn = '0, periphOe = '0, periphData = '0;
   logic [GPAP_NPORT-1:0] extEn = '0; // Outside world drives the undriven lines
   gpap_padDrv_t [GPAP_NPORT-1:0] padDrv;
   logic ccp2En = 1'b0, ccp2Oe = 1'b0, ccp2Data = 1'b0, ccp2In, ssIn;
   int bad_count = 0;
   int n_tests = 0;
   logic [31:0] rdq;

   gpap_port i_dut (.core_clk(core_clk), .sys_rst(sys_rst), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .padIn(padIn), .padDrv(padDrv), .inBufEn(inBufEn),
      .pullUpEn(pullUpEn), .periphEn(periphEn), .periphOe(periphOe), .periphData(periphData),
      .ccp2En(ccp2En), .ccp2Oe(ccp2Oe), .ccp2Data(ccp2Data), .ccp2In(ccp2In), .ssIn(ssIn));

   gpap_pads i_pads (.core_clk(core_clk), .padDrv(padDrv), .pullUpEn(pullUpEn),
      .extLevel(extLevel), .extEn(extEn), .padIn(padIn));

   // 100 ns clock
   initial begin
      forever #50 core_clk = ~core_clk;
   end

   // ***********************************************
   // Tasks
   // ***********************************************
   task automatic print_verdict();
      $display("Comparisons %0d, mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   // Single comparison point
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         bad_count++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // Byte address of a port register
   function automatic logic [GPAP_AW-1:0] adr(input int p, input int off);
      return GPAP_AW'(p * GPAP_PORT_STRIDE + off);
   endfunction

   // One Avalon cycle; request held until waitrequest is seen low
   task automatic bus(input logic w, input logic [6:0] a, input logic [7:0] d,
                      input logic [3:0] be, output logic [31:0] q);
      int k;
      @(posedge core_clk);
      avs_address <= a;
      avs_write <= w;
      avs_read <= ~w;
      avs_writedata <= {24'h0, d};
      avs_byteenable <= be;
      // Waitrequest sampled at each rising edge; the accept edge ends the wait
      for (k = 0; k < 16; k++) begin
         @(posedge core_clk);
         if (avs_waitrequest === 1'b0) break;
      end
      if (k == 16) begin
         bad_count++;
         print_verdict();
      end
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask

   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      bus(1'b1, a, d, 4'h1, rdq);
   endtask

   task automatic rdc(input string what, input logic [6:0] a, input logic [7:0] exp);
      bus(1'b0, a, 8'h00, 4'h1, rdq);
      chk(what, rdq, {24'h0, exp});
   endtask

   // Pads, synchroniser and routing flops all settle within this
   task automatic settle();
      repeat (6) @(posedge core_clk);
   endtask

   // Hang guard
   initial begin
      repeat (20000) @(posedge core_clk);
      bad_count++;
      print_verdict();
   end

   // ***********************************************
   // Tests
   // ***********************************************
   initial begin
      repeat (8) @(posedge core_clk);
      sys_rst <= 1'b0;
      @(posedge core_clk);
      @(negedge core_clk);
      chk("enable", padDrv[0].enable, 8'h00);
      chk("inbuf", inBufEn, '0);
      for (int p = 0; p < GPAP_NPORT; p++) begin
         rdc("dir", adr(p, GPAP_OFF_DIR), GPAP_RST_DIR);
         rdc("lat", adr(p, GPAP_OFF_LAT), GPAP_RST_LAT);
         rdc("ans", adr(p, GPAP_OFF_ANS), 8'hff);
         rdc("wpu", adr(p, GPAP_OFF_WPU), GPAP_RST_WPU);
         rdc("pin", adr(p, GPAP_OFF_PIN), 8'h00);
      end
      rdc("apf", adr(0, GPAP_OFF_APF), 8'h00);
      wr(7'h7c, 8'h5a);
      rdc("unmapped", 7'h7c, 8'h00);
      bus(1'b1, adr(0, GPAP_OFF_LAT), 8'hee, 4'h0, rdq);
      rdc("be0", adr(0, GPAP_OFF_LAT), 8'h00);
      $display("test reset done");

      // Latch, pin, direction, analog and pull-up per port
      for (int p = 0; p < GPAP_NPORT; p++) begin
         wr(adr(p, GPAP_OFF_ANS), 8'h00);
         wr(adr(p, GPAP_OFF_DIR), 8'h00);
         wr(adr(p, GPAP_OFF_LAT), 8'ha5);
         settle();
         chk("level", padDrv[p].level, 8'ha5);
         chk("enable", padDrv[p].enable, 8'hff);
         rdc("lat", adr(p, GPAP_OFF_LAT), 8'ha5);
         wr(adr(p, GPAP_OFF_PIN), 8'h3c);
         rdc("lat", adr(p, GPAP_OFF_LAT), 8'h3c);
         settle();
         rdc("pin", adr(p, GPAP_OFF_PIN), 8'h3c);
         extLevel[p] <= 8'h90;
         extEn[p] <= 1'b1;
         wr(adr(p, GPAP_OFF_DIR), 8'hf0);
         settle();
         chk("enable", padDrv[p].enable, 8'h0f);
         rdc("pin", adr(p, GPAP_OFF_PIN), 8'h9c);
         rdc("lat", adr(p, GPAP_OFF_LAT), 8'h3c);
         wr(adr(p, GPAP_OFF_ANS), 8'h0f);
         settle();
         chk("inbuf", inBufEn[p], 8'hf0);
         rdc("pin", adr(p, GPAP_OFF_PIN), 8'h90);
         wr(adr(p, GPAP_OFF_WPU), 8'h55);
         rdc("wpu", adr(p, GPAP_OFF_WPU), 8'h55);
         periphEn[p] <= 8'h03;
         periphOe[p] <= 8'h01;
         periphData[p] <= 8'h03;
         wr(adr(p, GPAP_OFF_ANS), 8'h00);
         settle();
         chk("pullup", pullUpEn[p], 8'h55);
         chk("enable", padDrv[p].enable, 8'h0d);
         chk("level", padDrv[p].level, 8'h3f);
         rdc("pin", adr(p, GPAP_OFF_PIN), 8'h9d);
         periphEn[p] <= 8'h00;
         $display("test port %0d done", p);
      end

      // Alternate pin steering
      extLevel[0] <= 8'h20;
      extLevel[2] <= 8'h02;
      wr(adr(0, GPAP_OFF_DIR), 8'hff);
      ccp2En <= 1'b1;
      ccp2Oe <= 1'b0;
      settle();
      chk("ss", ssIn, 1'b1);
      chk("c2en", padDrv[2].enable[1], 1'b0);
      chk("b3en", padDrv[1].enable[3], 1'b1);
      chk("c2in", ccp2In, 1'b1);
      wr(adr(0, GPAP_OFF_APF), 8'hff);
      rdc("apf", adr(0, GPAP_OFF_APF), 8'h03);
      settle();
      chk("ss", ssIn, 1'b0);
      chk("c2en", padDrv[2].enable[1], 1'b1);
      chk("b3en", padDrv[1].enable[3], 1'b0);
      chk("c2in", ccp2In, 1'b0);
      ccp2Oe <= 1'b1;
      ccp2Data <= 1'b0;
      settle();
      chk("b3lvl", padDrv[1].level[3], 1'b0);
      chk("b3en", padDrv[1].enable[3], 1'b1);
      rdc("dirb", adr(1, GPAP_OFF_DIR), 8'hf0);
      rdc("dirc", adr(2, GPAP_OFF_DIR), 8'hf0);
      $display("test steering done");

      // Mid-run reset puts every register back to its reset value
      sys_rst <= 1'b1;
      repeat (2) @(posedge core_clk);
      sys_rst <= 1'b0;
      @(posedge core_clk);
      rdc("ans", adr(1, GPAP_OFF_ANS), GPAP_RST_ANS);
      rdc("apf", adr(0, GPAP_OFF_APF), GPAP_RST_APF);
      rdc("dir", adr(2, GPAP_OFF_DIR), GPAP_RST_DIR);
      rdc("lat", adr(1, GPAP_OFF_LAT), GPAP_RST_LAT);
      $display("test reset again done");
      print_verdict();
   end
endmodule
